/* File: rtl/tap_fmt_pkg.sv */
// Constants for the three-tap video output formatter.
// Assumes a 40 MHz system clock and an oversampled link pixel clock.
package tap_fmt_pkg;
  localparam int          SYS_CLK_MHZ       = 40;
  localparam int          SYS_PERIOD_PS     = 25000;
  // Line valid delay bounds in nanoseconds
  localparam int          DLY40_PRG_MIN_NS  = 3080;
  localparam int          DLY40_PRG_MAX_NS  = 3200;
  localparam int          DLY40_EDG_MIN_NS  = 3130;
  localparam int          DLY40_EDG_MAX_NS  = 3250;
  localparam int          DLY80_PRG_MIN_NS  = 2910;
  localparam int          DLY80_PRG_MAX_NS  = 3010;
  localparam int          DLY80_EDG_MIN_NS  = 2960;
  localparam int          DLY80_EDG_MAX_NS  = 3040;
  // Least time rounds up to whole system cycles
  localparam int          DLY40_PRG_CYC = (DLY40_PRG_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int          DLY40_EDG_CYC = (DLY40_EDG_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int          DLY80_PRG_CYC = (DLY80_PRG_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int          DLY80_EDG_CYC = (DLY80_EDG_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int          DLY_W         = 8;
  localparam int          PIX_W         = 10;
  localparam int          PORT_W        = 8;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          LEN_W         = 16;
  // Exposure modes
  typedef enum logic [1:0] {
    EXP_PROGRAMMABLE = 2'b00,
    EXP_EDGE         = 2'b01,
    EXP_LEVEL        = 2'b10
  } exp_mode_e;
  // AHB-Lite register byte offsets
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_LEN    = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_COUNT  = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] LEN_RESET  = 16'h0000;
  // Control bit positions
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_8BIT_BIT  = 1;
  localparam int          CTRL_80MHZ_BIT = 2;
  localparam int          CTRL_EXP_LSB   = 4;
endpackage : tap_fmt_pkg

/* File: rtl/tap_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tap_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      fill_reg;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign wr_ready_out = (fill_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (fill_reg != '0);
  assign rd_data_out  = mem_reg[rd_ptr_reg];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  // Storage, written only on push
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg   <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tap_fifo
`default_nettype wire

/* File: rtl/tap_formatter.sv */
// Three-tap video output formatter with AHB-Lite control registers.
// Assumes pixels arrive as 3-pixel words with a last flag, and that the
// link pixel clock is an outside input slower than a quarter of CLK_SYS_IN.
// Overview of operation
// - With nothing valid to send, line valid and data valid stay low every pixel clock.
// - A line is only sent after the exposure ends and sensor readout has completed.
// - The first cycle of a line raises both flags and carries pixels one, two, three on the three taps.
// - Each following pixel clock advances three pixels with both flags held high.
// - After the last pixel both flags fall together.
// - Pixels go out at 10-bit or 8-bit depth per the selected mode.
// - In 10-bit mode transmitter one carries tap one on A and B0-B1 and tap three on B4-B5 and C.
// - In 8-bit mode transmitter one alone carries taps one to three on A, B and C, frame valid low.
// - In 10-bit mode transmitter two carries tap two on E and F0-F1 and repeats the flags.
// - The line valid delay depends on acquisition mode, link clock speed and sensor size; here only exposure mode and link speed select it.
// - At 40 MHz the delay is 3.08-3.20 us, or 3.13-3.25 us in edge-controlled exposure.
// - At 80 MHz the delay is 2.91-3.01 us, or 2.96-3.04 us in edge-controlled exposure.
// - Tap data and flags launch on each rising edge of the link pixel clock.
// - In 8-bit mode the two lowest converter bits are dropped.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tap_formatter #(
  parameter int PIX_W      = tap_fmt_pkg::PIX_W,
  parameter int FIFO_DEPTH = tap_fmt_pkg::FIFO_DEPTH
) (
  input  wire logic               CLK_SYS_IN,
  input  wire logic               SYS_RST_IN,
  // AHB-Lite slave
  input  wire logic               HSEL_IN,
  input  wire logic [31:0]        HADDR_IN,
  input  wire logic [1:0]         HTRANS_IN,
  input  wire logic               HWRITE_IN,
  input  wire logic [2:0]         HSIZE_IN,
  input  wire logic [31:0]        HWDATA_IN,
  input  wire logic               HREADY_IN,
  output logic      [31:0]        HRDATA_OUT,
  output logic                    HREADYOUT_OUT,
  output logic                    HRESP_OUT,
  // Sensor side
  input  wire logic               READOUT_DONE_IN,
  input  wire logic               PIX_VALID_IN,
  output logic                    PIX_READY_OUT,
  input  wire logic [3*PIX_W-1:0] PIX_DATA_IN,
  input  wire logic [1:0]         PIX_COUNT_IN,
  input  wire logic               PIX_LAST_IN,
  // Link
  input  wire logic               LINK_CLK_IN,
  output logic      [7:0]         PORT_A_OUT,
  output logic      [7:0]         PORT_B_OUT,
  output logic      [7:0]         PORT_C_OUT,
  output logic                    X_LVAL_OUT,
  output logic                    X_FVAL_OUT,
  output logic                    X_DVAL_OUT,
  output logic      [7:0]         PORT_D_OUT,
  output logic      [7:0]         PORT_E_OUT,
  output logic      [7:0]         PORT_F_OUT,
  output logic                    Y_LVAL_OUT,
  output logic                    Y_FVAL_OUT,
  output logic                    Y_DVAL_OUT
);
  localparam int FW = 3 * PIX_W + 3;
  localparam int OW = $clog2(FIFO_DEPTH) + 1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_SEND  = 2'b10
  } fmt_state_e;

  fmt_state_e                     state_reg;
  logic [31:0]                    ctrl_reg;
  logic [31:0]                    line_count_reg;
  logic [tap_fmt_pkg::DLY_W-1:0]  delay_cnt_reg;
  logic [2:0]                     link_sync_reg;
  logic [1:0]                     done_sync_reg;
  logic                           done_seen_reg;
  logic                           link_rise;
  logic [tap_fmt_pkg::DLY_W-1:0]  delay_target;
  logic                           fifo_ready;
  logic                           fifo_valid;
  logic [FW-1:0]                  fifo_data;
  logic                           take_word;
  logic [PIX_W-1:0]               tap0;
  logic [PIX_W-1:0]               tap1;
  logic [PIX_W-1:0]               tap2;
  logic [1:0]                     word_cnt;
  logic                           word_last;
  logic                           mode_8bit;
  logic                           addr_ph_reg;
  logic                           wr_ph_reg;
  logic [7:0]                     addr_reg;
  logic [OW-1:0]                  occ_reg;
  logic [OW-1:0]                  occ_next;
  logic                           pix_push;

  // Stream buffer; the registered occupancy ready, not its own ready, stalls the sensor side
  tap_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (CLK_SYS_IN),
    .rst_in       (SYS_RST_IN),
    .wr_valid_in  (pix_push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   ({PIX_LAST_IN, PIX_COUNT_IN, PIX_DATA_IN}),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (take_word),
    .rd_data_out  (fifo_data)
  );

  // Sensor words accepted only while the registered ready stands high
  assign pix_push = PIX_VALID_IN && PIX_READY_OUT;
  assign occ_next = occ_reg + OW'(pix_push) - OW'(take_word);

  // Own occupancy count, so the registered ready already counts the word
  // taken on this edge; a copy of the FIFO's full flag would lag a cycle
  // and accept one word too many once the buffer fills.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      occ_reg       <= '0;
      PIX_READY_OUT <= 1'b0;
    end else begin
      occ_reg       <= occ_next;
      PIX_READY_OUT <= (occ_next != OW'(FIFO_DEPTH));
    end
  end

  assign {word_last, word_cnt, tap2, tap1, tap0} = fifo_data;
  assign mode_8bit = ctrl_reg[tap_fmt_pkg::CTRL_8BIT_BIT];

  // Two-stage sync of link clock and readout done; third link stage finds link rising edges
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      link_sync_reg <= '0;
      done_sync_reg <= '0;
    end else begin
      link_sync_reg <= {link_sync_reg[1:0], LINK_CLK_IN};
      done_sync_reg <= {done_sync_reg[0], READOUT_DONE_IN};
    end
  end
  assign link_rise = link_sync_reg[1] && !link_sync_reg[2];

  // delay chosen by speed and exposure mode
  always_comb begin
    if (ctrl_reg[tap_fmt_pkg::CTRL_80MHZ_BIT]) begin
      if (ctrl_reg[tap_fmt_pkg::CTRL_EXP_LSB +: 2] == tap_fmt_pkg::EXP_EDGE) begin
        delay_target = tap_fmt_pkg::DLY_W'(tap_fmt_pkg::DLY80_EDG_CYC);
      end else begin
        delay_target = tap_fmt_pkg::DLY_W'(tap_fmt_pkg::DLY80_PRG_CYC);
      end
    end else begin
      if (ctrl_reg[tap_fmt_pkg::CTRL_EXP_LSB +: 2] == tap_fmt_pkg::EXP_EDGE) begin
        delay_target = tap_fmt_pkg::DLY_W'(tap_fmt_pkg::DLY40_EDG_CYC);
      end else begin
        delay_target = tap_fmt_pkg::DLY_W'(tap_fmt_pkg::DLY40_PRG_CYC);
      end
    end
  end

  // Synchronized readout-done level latched so a short pulse is not lost
  // Consumed once the delay starts; a flag still set on return to idle
  // would start a line that no readout has finished
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      done_seen_reg <= 1'b0;
    end else if (done_sync_reg[1]) begin
      done_seen_reg <= 1'b1;
    end else if (state_reg == ST_DELAY) begin
      done_seen_reg <= 1'b0;
    end
  end

  // Word taken only on a link edge while sending
  assign take_word = (state_reg == ST_SEND) && link_rise && fifo_valid;

  // Line sequencer
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state_reg      <= ST_IDLE;
      delay_cnt_reg  <= '0;
      line_count_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (done_seen_reg && ctrl_reg[tap_fmt_pkg::CTRL_EN_BIT]) begin
            state_reg     <= ST_DELAY;
            delay_cnt_reg <= '0;
          end
        end
        ST_DELAY: begin
          // Least delay; the link edge wait adds at most one link period
          if (delay_cnt_reg >= delay_target) begin
            state_reg <= ST_SEND;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 1'b1;
          end
        end
        ST_SEND: begin
          if (take_word && word_last) begin
            state_reg      <= ST_IDLE;
            line_count_reg <= line_count_reg + 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Output ports, registered and updated on link edges only
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      {PORT_A_OUT, PORT_B_OUT, PORT_C_OUT} <= '0;
      {PORT_D_OUT, PORT_E_OUT, PORT_F_OUT} <= '0;
      {X_LVAL_OUT, X_DVAL_OUT, Y_LVAL_OUT, Y_DVAL_OUT} <= '0;
      X_FVAL_OUT <= 1'b0;
      Y_FVAL_OUT <= 1'b0;
    end else if (link_rise) begin
      // Frame valid unused in this line mode
      X_FVAL_OUT <= 1'b0;
      Y_FVAL_OUT <= 1'b0;
      PORT_D_OUT <= '0;
      if (take_word) begin
        // first word raises both flags; later words hold them
        X_LVAL_OUT <= 1'b1;
        X_DVAL_OUT <= 1'b1;
        Y_LVAL_OUT <= 1'b1;
        Y_DVAL_OUT <= 1'b1;
        if (mode_8bit) begin
          // top eight bits on A, B, C
          PORT_A_OUT <= tap0[PIX_W-1 -: 8];
          PORT_B_OUT <= (word_cnt >= 2'd2 || word_cnt == 2'd0) ? tap1[PIX_W-1 -: 8] : 8'h00;
          PORT_C_OUT <= (word_cnt == 2'd0) ? tap2[PIX_W-1 -: 8] : 8'h00;
          PORT_E_OUT <= '0;
          PORT_F_OUT <= '0;
        end else begin
          // tap one on A/B0-1, tap three on C/B4-5
          PORT_A_OUT <= tap0[7:0];
          PORT_C_OUT <= (word_cnt == 2'd0) ? tap2[7:0] : 8'h00;
          PORT_B_OUT <= {2'b00, (word_cnt == 2'd0) ? tap2[9:8] : 2'b00, 2'b00, tap0[9:8]};
          // tap two on E and F0-1
          PORT_E_OUT <= (word_cnt == 2'd1) ? 8'h00 : tap1[7:0];
          PORT_F_OUT <= {6'b00_0000, (word_cnt == 2'd1) ? 2'b00 : tap1[9:8]};
        end
      end else begin
        // flags low when nothing is sent
        X_LVAL_OUT <= 1'b0;
        X_DVAL_OUT <= 1'b0;
        Y_LVAL_OUT <= 1'b0;
        Y_DVAL_OUT <= 1'b0;
        {PORT_A_OUT, PORT_B_OUT, PORT_C_OUT} <= '0;
        PORT_E_OUT <= '0;
        PORT_F_OUT <= '0;
      end
    end
  end

  // AHB-Lite address phase capture; always zero wait, OKAY
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      addr_ph_reg <= 1'b0;
      wr_ph_reg   <= 1'b0;
      addr_reg    <= '0;
    end else if (HREADY_IN) begin
      addr_ph_reg <= HSEL_IN && HTRANS_IN[1];
      wr_ph_reg   <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
      addr_reg    <= HADDR_IN[7:0];
    end
  end

  // Control register written in data phase
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ctrl_reg <= tap_fmt_pkg::CTRL_RESET;
    end else if (wr_ph_reg && addr_reg == tap_fmt_pkg::REG_CTRL) begin
      ctrl_reg <= HWDATA_IN;
    end
  end

  // Read data registered from the address phase
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      HRDATA_OUT    <= '0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
      unique case (HADDR_IN[7:0])
        tap_fmt_pkg::REG_CTRL:   HRDATA_OUT <= ctrl_reg;
        tap_fmt_pkg::REG_STATUS: HRDATA_OUT <= {27'h000_0000, fifo_valid, fifo_ready,
                                                done_seen_reg, state_reg};
        tap_fmt_pkg::REG_COUNT:  HRDATA_OUT <= line_count_reg;
        default:                 HRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end
endmodule : tap_formatter
`default_nettype wire

/* File: test/tap_fmt_assertions.sv */
// Port checker for the three-tap formatter.
// Assumes a link clock far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none
module tap_fmt_checker (
  input wire logic       CLK_SYS_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       READOUT_DONE_IN,
  input wire logic       LINK_CLK_IN,
  input wire logic [7:0] PORT_A_OUT,
  input wire logic [7:0] PORT_C_OUT,
  input wire logic [7:0] PORT_D_OUT,
  input wire logic       X_LVAL_OUT,
  input wire logic       X_FVAL_OUT,
  input wire logic       X_DVAL_OUT,
  input wire logic       Y_LVAL_OUT,
  input wire logic       Y_FVAL_OUT
);
  logic       link_q;
  logic       done_q;
  logic       armed;
  logic [5:0] rose_h;
  logic [9:0] age;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Link rise history; outputs may only move shortly after one
  always_ff @(posedge CLK_SYS_IN) begin
    link_q <= LINK_CLK_IN;
    rose_h <= {rose_h[4:0], LINK_CLK_IN & ~link_q};
  end
  // Age of last readout edge, armed until its line ends
  always_ff @(posedge CLK_SYS_IN) begin
    done_q <= READOUT_DONE_IN;
    if (SYS_RST_IN) begin
      armed <= 1'b0;
      age   <= 10'h000;
    end else if (READOUT_DONE_IN && !done_q) begin
      armed <= 1'b1;
      age   <= 10'h000;
    end else begin
      if (age != 10'h3ff) age <= age + 10'h001;
      if ($fell(X_LVAL_OUT)) armed <= 1'b0;
    end
  end
  flags_together_a:
    assert property (X_LVAL_OUT == X_DVAL_OUT) else $error("line and data valid differ");
  y_follows_x_a:
    assert property (Y_LVAL_OUT |-> X_LVAL_OUT) else $error("second line valid without first");
  fval_low_a:
    assert property (!X_FVAL_OUT && !Y_FVAL_OUT) else $error("frame valid driven");
  port_d_low_a:
    assert property (PORT_D_OUT == 8'h00) else $error("unused port D not low");
  launch_edge_a:
    assert property (($changed(X_LVAL_OUT) || $changed(PORT_A_OUT)) |-> |rose_h[4:1])
      else $error("output moved away from a link rise");
  line_delay_a:
    assert property ($rose(X_LVAL_OUT) |-> age >= 10'h075) else $error("line valid too early");
  line_after_done_a:
    assert property ($rose(X_LVAL_OUT) |-> armed) else $error("line without readout done");
  first_word_a:
    assert property ($rose(X_LVAL_OUT) |=> (X_LVAL_OUT && $stable(PORT_A_OUT) && $stable(PORT_C_OUT))[*4])
      else $error("first word did not stand");
endmodule : tap_fmt_checker
`default_nettype wire

/* File: test/grabber_model.sv */
// Frame grabber model: takes a word on each link rise with X line and data valid high.
// Assumes outputs settle well before the next link rise.
`timescale 1ns/1ps
`default_nettype none
module grabber_model (
  input  wire logic       link_in,
  input  wire logic       mode8_in,
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] b_in,
  input  wire logic [7:0] c_in,
  input  wire logic [7:0] d_in,
  input  wire logic [7:0] e_in,
  input  wire logic [7:0] f_in,
  input  wire logic       xl_in,
  input  wire logic       xd_in,
  input  wire logic       yl_in,
  input  wire logic       yd_in,
  output logic     [29:0] taps_out,
  output logic            fault_out,
  output int              words_out
);
  always @(posedge link_in) begin
    if (xl_in && xd_in) begin
      if (mode8_in) begin
        taps_out  <= {2'h0, c_in, 2'h0, b_in, 2'h0, a_in};
        fault_out <= |{d_in, e_in, f_in};
      end else begin
        taps_out  <= {b_in[5:4], c_in, f_in[1:0], e_in, b_in[1:0], a_in};
        fault_out <= |{d_in, f_in[7:2], b_in[7:6], b_in[3:2]} || yl_in != xl_in || yd_in != xd_in;
      end
      words_out <= words_out + 1;
    end
  end
endmodule : grabber_model
`default_nettype wire

/* File: test/test_three_tap_video_output_formatter.sv */
// Bench: bus setup, sensor feed and link checks per mode.
// Assumes the checker and grabber model compile first.
`timescale 1ns/1ps
`default_nettype none
module test_three_tap_video_output_formatter;
  logic        clk, rst, hsel, hwrite, done, pvalid, plast, link, mode8;
  logic        hready, hresp, pready, xl, xf, xd, yl, yf, yd, fault;
  logic [1:0]  htrans, pcount;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [29:0] pdata, taps;
  logic [7:0]  pa, pb, pc, pd, pe, pf;
  logic [29:0] exp_q[$];
  logic [5:0]  cfg[7] = '{6'h01, 6'h11, 6'h21, 6'h05, 6'h15, 6'h27, 6'h13};
  int          words, seed = 32'h1b26_eca6, miscompares = 0, n_compared = 0;
  tap_formatter i_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .READOUT_DONE_IN(done),
    .PIX_VALID_IN(pvalid), .PIX_READY_OUT(pready), .PIX_DATA_IN(pdata), .PIX_COUNT_IN(pcount),
    .PIX_LAST_IN(plast), .LINK_CLK_IN(link), .PORT_A_OUT(pa), .PORT_B_OUT(pb), .PORT_C_OUT(pc),
    .X_LVAL_OUT(xl), .X_FVAL_OUT(xf), .X_DVAL_OUT(xd), .PORT_D_OUT(pd), .PORT_E_OUT(pe),
    .PORT_F_OUT(pf), .Y_LVAL_OUT(yl), .Y_FVAL_OUT(yf), .Y_DVAL_OUT(yd));
  grabber_model i_grab (.link_in(link), .mode8_in(mode8), .a_in(pa), .b_in(pb), .c_in(pc),
    .d_in(pd), .e_in(pe), .f_in(pf), .xl_in(xl), .xd_in(xd), .yl_in(yl), .yd_in(yd),
    .taps_out(taps), .fault_out(fault), .words_out(words));
  // Clocks; link phase unrelated to the system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link = 1'b0;
    #41;
    forever #100 link = ~link;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      miscompares++;
    end
  endtask : chk
  // Bounded wait for a handshake level at a rising edge
  task automatic await(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== v && n < 2000);
    chk("handshake wait", {31'h0000_0000, v}, {31'h0000_0000, s});
  endtask : await
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    await(hready, 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    await(hready, 1'b1);
    rd = hrdata;
    chk("bus response", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : ahb
  // Sensor feed; each accepted word notes its expected taps
  task automatic push(input int nw, input logic m8);
    logic [29:0] w, e;
    logic [1:0]  k;
    for (int i = 0; i < nw; i++) begin
      w = 30'($random(seed));
      k = (i == nw - 1) ? 2'({$random(seed)} % 3) : 2'h0;
      e = w;
      if (k == 2'h1) e[29:10] = '0;
      if (k == 2'h2) e[29:20] = '0;
      if (m8) e = {2'h0, e[29:22], 2'h0, e[19:12], 2'h0, e[9:2]};
      pvalid <= 1'b1;
      pdata  <= w;
      pcount <= k;
      plast  <= (i == nw - 1);
      await(pready, 1'b1);
      exp_q.push_back(e);
    end
    pvalid <= 1'b0;
  endtask : push
  task automatic line(input logic [5:0] c, input int nw);
    int n, lo, hi;
    lo = c[2] ? (c[4] ? 2960 : 2910) : (c[4] ? 3130 : 3080);
    hi = c[2] ? (c[4] ? 3040 : 3010) : (c[4] ? 3250 : 3200);
    ahb(1'b1, 32'h0000_0000, {26'h000_0000, c});
    mode8 <= c[1];
    fork
      push(nw, c[1]);
      begin
        repeat (60) @(posedge clk);
        chk("early line valid", 32'h0000_0000, {31'h0000_0000, xl});
        done <= 1'b1;
        n = 0;
        while (xl !== 1'b1 && n < 400) begin
          @(posedge clk);
          n++;
          if (n == 3) done <= 1'b0;
        end
        // Window widened by one link period and launch latency
        chk("line valid delay", 32'h0000_0001, 32'(n * 25 >= lo && n * 25 <= hi + 300));
      end
    join
    await(xl, 1'b0);
    repeat (16) @(posedge clk);
    chk("words left", 32'h0000_0000, 32'(exp_q.size()));
  endtask : line
  // Oldest noted word against each word the grabber takes
  always @(words) begin
    #1;
    chk("spare bits", 32'h0000_0000, {31'h0000_0000, fault});
    if (exp_q.size() == 0) chk("extra word", 32'h0000_0001, 32'h0000_0000);
    else chk("taps", {2'h0, exp_q.pop_front()}, {2'h0, taps});
  end
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, done, pvalid, plast, pcount, pdata, mode8} = '0;
    hsize = 3'h2;
    rst   = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk("ctrl reset", tap_fmt_pkg::CTRL_RESET, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    for (int i = 0; i < 7; i++) line(cfg[i], 9 + i);
    ahb(1'b0, 32'(tap_fmt_pkg::REG_COUNT), 32'h0000_0000);
    chk("lines sent", 32'h0000_0007, rd);
    conclude();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #400_000;
    miscompares++;
    conclude();
  end
endmodule : test_three_tap_video_output_formatter
bind tap_formatter tap_fmt_checker i_chk (.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN),
  .READOUT_DONE_IN(READOUT_DONE_IN), .LINK_CLK_IN(LINK_CLK_IN), .PORT_A_OUT(PORT_A_OUT),
  .PORT_C_OUT(PORT_C_OUT), .PORT_D_OUT(PORT_D_OUT), .X_LVAL_OUT(X_LVAL_OUT), .X_FVAL_OUT(X_FVAL_OUT),
  .X_DVAL_OUT(X_DVAL_OUT), .Y_LVAL_OUT(Y_LVAL_OUT), .Y_FVAL_OUT(Y_FVAL_OUT));
`default_nettype wire
